// file: logic/ufc_top.sv
// user feature configuration word and the settings it drives
//
// Functional notes
// [RQ1] during a ramp, duty is held at least (N+1)/256 of the period
// [RQ2] minimum duty floor applies only while its enable bit is set
// [RQ3] with time-out set, sync output stops 500 ms after disable
// [RQ4] feed-forward bit clear means coefficients corrected for supply
// [RQ5] spread bit clear: ignore peer faults, or sequence down if enabled
// [RQ6] spread bit set: any group fault shuts the output down at once
// [RQ7] host keeps the three link transmit control bits at zero
// [RQ8] sync-use bit clear: auto-configure; set: switch on sync input clock
// [RQ9] sync-output bit clear: pin input only; set: drive internal clock out (code drives it only while the sync-use bit is clear)
// [RQ10] while disabled, low-side drive follows its control bit
// [RQ11] standby 00: low power when disabled, no telemetry readings
// [RQ12] standby 01 continuous monitor, 11 pulsed monitor, 10 reserved
// [RQ13] reset value of the word is 2011h
// [RQ14] register is read and written as one two-byte word
// [RQ15] driven sync pin is open-drain or push-pull per manufacturer bit
// [RQ16] reserved bits 12 and 10 read zero and do nothing
`timescale 1ns/100ps
module ufc_top #(
    parameter int unsigned SYNC_TMO_CYC = ufc_pkg::SYNC_TMO_CYC
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    // decoded management-link word command
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_write_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [15:0] cmd_wdata_i,
    output logic             cmd_hit_o,
    output logic             rd_valid_o,
    output logic [15:0]      rd_data_o,
    // device state
    input  wire logic        dev_en_i,
    input  wire logic        ramp_active_i,
    input  wire logic        seq_en_i,
    input  wire logic        ext_fault_i,
    input  wire logic        tele_read_i,
    input  wire logic        sync_drive_pp_i,
    // pwm engine
    input  wire logic [7:0]  duty_req_i,
    input  wire logic        pwm_low_i,
    input  wire logic        sw_clk_i,
    output logic [7:0]       duty_o,
    output logic             ls_on_o,
    // sync pin
    input  wire logic        sync_pin_i,
    output logic             sync_pin_o,
    output logic             sync_pin_oe_n_o,
    output logic             sync_rx_o,
    // settings to oscillator, loop and fault logic
    output logic             clk_ext_o,
    output logic             ff_correct_o,
    output logic             shutdown_o,
    output logic             seq_down_o,
    // standby behaviour
    output logic             lowpower_o,
    output logic             mon_cont_o,
    output logic             mon_pulse_o,
    output logic             tele_avail_o
);

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] rd_data;
        logic        rd_valid;
        logic        hit;
        logic [7:0]  duty;
        logic        ls_on;
        logic        sync_out;
        logic        sync_oe_n;
        logic        shutdown;
        logic        seq_down;
        logic        lowpower;
        logic        mon_cont;
        logic        mon_pulse;
        logic        tele_avail;
        logic        ff_correct;
        logic        clk_ext;
    } ufc_top_state_t;

    localparam ufc_top_state_t RST_STATE = '{
        cfg:        ufc_pkg::CFG_RESET,
        rd_data:    16'h0000,
        rd_valid:   1'b0,
        hit:        1'b0,
        duty:       8'h00,
        ls_on:      1'b0,
        sync_out:   1'b0,
        sync_oe_n:  1'b1,
        shutdown:   1'b0,
        seq_down:   1'b0,
        lowpower:   1'b0,
        mon_cont:   1'b0,
        mon_pulse:  1'b0,
        tele_avail: 1'b0,
        ff_correct: 1'b0,
        clk_ext:    1'b0
    };

    ufc_top_state_t q;
    ufc_top_state_t d;

    logic       tmo_exp;
    logic       sync_drive;
    logic [1:0] stby;
    logic [7:0] duty_floor;
    logic       our_cmd;

    ufc_sync2 i_ufc_sync2 (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .async_i   (sync_pin_i),
        .sync_o    (sync_rx_o)
    );

    // runs only while the device is disabled
    ufc_sync_timer #(
        .CNT_W (ufc_pkg::TMO_CNT_W),
        .LIMIT (SYNC_TMO_CYC)
    ) i_ufc_sync_timer (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .run_i     (!dev_en_i),
        .expired_o (tmo_exp)
    );

    always_comb begin
        d          = q;
        our_cmd    = cmd_valid_i && (cmd_code_i == ufc_pkg::CMD_CODE);
        stby       = q.cfg[ufc_pkg::STBY_HI:ufc_pkg::STBY_LO];
        duty_floor = {6'h00, q.cfg[ufc_pkg::MIN_N_HI:ufc_pkg::MIN_N_LO]}
                     + ufc_pkg::DUTY_STEP; // see [RQ1]
        // whole-word access; reserved bits never stored
        d.hit      = our_cmd; // see [RQ14]
        d.rd_valid = our_cmd && !cmd_write_i;
        if (our_cmd && !cmd_write_i) begin
            d.rd_data = q.cfg; // see [RQ14]
        end
        if (our_cmd && cmd_write_i) begin
            d.cfg = cmd_wdata_i & ufc_pkg::CFG_WR_MASK; // see [RQ16]
        end
        // transmit control bits are stored but steer nothing, see [RQ7]
        // ramp floor
        if (q.cfg[ufc_pkg::MIN_EN_BIT] && ramp_active_i &&
            (duty_req_i < duty_floor)) begin
            d.duty = duty_floor; // see [RQ1]
        end else begin
            d.duty = duty_req_i; // see [RQ2]
        end
        // low-side drive
        if (dev_en_i) begin
            d.ls_on = pwm_low_i;
        end else begin
            d.ls_on = q.cfg[ufc_pkg::LS_ON_BIT]; // see [RQ10]
        end
        // sync pin drive
        sync_drive = q.cfg[ufc_pkg::SYNC_OUT_BIT] &&
                     !q.cfg[ufc_pkg::SYNC_USE_BIT] && // see [RQ9]
                     !(q.cfg[ufc_pkg::TMO_EN_BIT] && tmo_exp); // see [RQ3]
        if (!sync_drive) begin
            d.sync_out  = 1'b0;
            d.sync_oe_n = 1'b1;
        end else if (sync_drive_pp_i) begin
            d.sync_out  = sw_clk_i; // see [RQ15]
            d.sync_oe_n = 1'b0;
        end else begin
            // open-drain: pull low only, release for the high phase
            d.sync_out  = 1'b0; // see [RQ15]
            d.sync_oe_n = sw_clk_i;
        end
        d.clk_ext    = q.cfg[ufc_pkg::SYNC_USE_BIT]; // see [RQ8]
        d.ff_correct = !q.cfg[ufc_pkg::FF_OFF_BIT]; // see [RQ4]
        // fault spreading
        d.shutdown = q.cfg[ufc_pkg::SPREAD_BIT] && ext_fault_i; // see [RQ6]
        d.seq_down = !q.cfg[ufc_pkg::SPREAD_BIT] && seq_en_i &&
                     ext_fault_i; // see [RQ5]
        // standby; the reserved code behaves as low power
        d.lowpower   = !dev_en_i && ((stby == ufc_pkg::STBY_LOWPWR) ||
                       (stby == ufc_pkg::STBY_RSVD)); // see [RQ11]
        d.mon_cont   = !dev_en_i && (stby == ufc_pkg::STBY_CONT); // see [RQ12]
        d.mon_pulse  = !dev_en_i && (stby == ufc_pkg::STBY_PULSED) &&
                       tele_read_i; // see [RQ12]
        d.tele_avail = dev_en_i || (stby == ufc_pkg::STBY_CONT) ||
                       (stby == ufc_pkg::STBY_PULSED); // see [RQ11]
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q <= RST_STATE; // see [RQ13]
        end else begin
            q <= d;
        end
    end

    assign cmd_hit_o       = q.hit;
    assign rd_valid_o      = q.rd_valid;
    assign rd_data_o       = q.rd_data;
    assign duty_o          = q.duty;
    assign ls_on_o         = q.ls_on;
    assign sync_pin_o      = q.sync_out;
    assign sync_pin_oe_n_o = q.sync_oe_n;
    assign clk_ext_o       = q.clk_ext;
    assign ff_correct_o    = q.ff_correct;
    assign shutdown_o      = q.shutdown;
    assign seq_down_o      = q.seq_down;
    assign lowpower_o      = q.lowpower;
    assign mon_cont_o      = q.mon_cont;
    assign mon_pulse_o     = q.mon_pulse;
    assign tele_avail_o    = q.tele_avail;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_word_write;
        cmd_valid_i && cmd_write_i && (cmd_code_i == ufc_pkg::CMD_CODE);
    endsequence

    sequence s_word_read;
        cmd_valid_i && !cmd_write_i && (cmd_code_i == ufc_pkg::CMD_CODE);
    endsequence

    sequence s_sync_timed_out;
        !dev_en_i && q.cfg[ufc_pkg::TMO_EN_BIT] && tmo_exp;
    endsequence

    reset_value_a: assert property ( // see [RQ13]
        $fell(srst_i) |-> (q.cfg == ufc_pkg::CFG_RESET))
        else $error("config word not at reset value");

    word_write_a: assert property ( // see [RQ16]
        s_word_write |=> (q.cfg == ($past(cmd_wdata_i) &
                                   ufc_pkg::CFG_WR_MASK)))
        else $error("written word not stored with reserved bits clear");

    word_read_a: assert property ( // see [RQ14]
        s_word_read ##1 (!cmd_valid_i) |->
            (rd_valid_o && cmd_hit_o && (rd_data_o == $past(q.cfg))))
        else $error("word read did not return the config word");

    duty_floor_a: assert property ( // see [RQ1]
        (ramp_active_i && q.cfg[ufc_pkg::MIN_EN_BIT]) |=>
            (duty_o >= $past(duty_floor)))
        else $error("ramp duty below configured floor");

    no_floor_a: assert property ( // see [RQ2]
        !q.cfg[ufc_pkg::MIN_EN_BIT] |=> (duty_o == $past(duty_req_i)))
        else $error("duty altered with floor disabled");

    spread_stop_a: assert property ( // see [RQ6]
        (q.cfg[ufc_pkg::SPREAD_BIT] && ext_fault_i) |=>
            (shutdown_o && !seq_down_o))
        else $error("group fault did not shut down output");

    fault_ignore_a: assert property ( // see [RQ5]
        (!q.cfg[ufc_pkg::SPREAD_BIT] && !seq_en_i) |=>
            (!shutdown_o && !seq_down_o))
        else $error("peer fault not ignored");

    ls_disabled_a: assert property ( // see [RQ10]
        !dev_en_i |=> (ls_on_o == $past(q.cfg[ufc_pkg::LS_ON_BIT])))
        else $error("low-side drive wrong while disabled");

    sync_input_a: assert property ( // see [RQ9]
        (!q.cfg[ufc_pkg::SYNC_OUT_BIT] || q.cfg[ufc_pkg::SYNC_USE_BIT])
            |=> sync_pin_oe_n_o)
        else $error("sync pin driven while input only");

    sync_timeout_a: assert property ( // see [RQ3]
        s_sync_timed_out |=> (sync_pin_oe_n_o && !sync_pin_o))
        else $error("sync still driven after time-out");

    standby_low_a: assert property ( // see [RQ11]
        (!dev_en_i && (stby == ufc_pkg::STBY_LOWPWR)) |=>
            (lowpower_o && !tele_avail_o && !mon_cont_o))
        else $error("low-power standby not entered");

    pulse_mon_a: assert property ( // see [RQ12]
        (!dev_en_i && (stby == ufc_pkg::STBY_PULSED) && tele_read_i) |=>
            (mon_pulse_o && tele_avail_o) ##1
            (!mon_pulse_o || $past(tele_read_i)))
        else $error("pulsed monitor not triggered by read");

endmodule // ufc_top

// file: pkg/ufc_pkg.sv
// constants of the user feature configuration register bank
package ufc_pkg;

    // command code and word layout
    localparam logic [7:0]  CMD_CODE     = 8'hD1;
    localparam logic [15:0] CFG_RESET    = 16'h2011;
    localparam logic [15:0] CFG_WR_MASK  = 16'hEBFF;

    // field positions
    localparam int MIN_N_HI    = 15;
    localparam int MIN_N_LO    = 14;
    localparam int MIN_EN_BIT  = 13;
    localparam int TMO_EN_BIT  = 11;
    localparam int FF_OFF_BIT  = 9;
    localparam int SPREAD_BIT  = 8;
    localparam int TX_RATE_BIT = 7;
    localparam int SYNC_USE_BIT = 6;
    localparam int SYNC_OUT_BIT = 5;
    localparam int TX_INH_BIT  = 4;
    localparam int TMO_INH_BIT = 3;
    localparam int LS_ON_BIT   = 2;
    localparam int STBY_HI     = 1;
    localparam int STBY_LO     = 0;

    // standby field codes
    localparam logic [1:0] STBY_LOWPWR = 2'h0;
    localparam logic [1:0] STBY_CONT   = 2'h1;
    localparam logic [1:0] STBY_RSVD   = 2'h2;
    localparam logic [1:0] STBY_PULSED = 2'h3;

    // duty is expressed in 1/256 of the switching period
    localparam int         DUTY_W      = 8;
    localparam logic [7:0] DUTY_STEP   = 8'h01;

    // sync time-out after disable
    localparam int unsigned SYNC_TMO_MS  = 500;
    localparam int unsigned CLK_KHZ      = 100000;
    localparam int unsigned SYNC_TMO_CYC = SYNC_TMO_MS * CLK_KHZ;
    localparam int          TMO_CNT_W    = 26;

endpackage : ufc_pkg

// file: logic/ufc_sync2.sv
// two flip-flop synchronizer for a pin level
`timescale 1ns/100ps
module ufc_sync2 (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    // pin side and synchronized level
    input  wire logic async_i,
    output logic      sync_o
);

    typedef struct packed {
        logic s1;
        logic s2;
    } ufc_sync2_state_t;

    ufc_sync2_state_t q;
    ufc_sync2_state_t d;

    always_comb begin
        d    = q;
        d.s1 = async_i;
        d.s2 = q.s1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.s2;

endmodule // ufc_sync2

// file: logic/ufc_sync_timer.sv
// counts cycles while running and flags expiry, saturating
`timescale 1ns/100ps
module ufc_sync_timer #(
    parameter int          CNT_W = ufc_pkg::TMO_CNT_W,
    parameter int unsigned LIMIT = ufc_pkg::SYNC_TMO_CYC
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    // control and status
    input  wire logic run_i,
    output logic      expired_o
);

    localparam logic [CNT_W-1:0] LIM_M1 = CNT_W'(LIMIT - 1);
    localparam logic [CNT_W-1:0] ONE    = CNT_W'(1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             expired;
    } ufc_timer_state_t;

    ufc_timer_state_t q;
    ufc_timer_state_t d;

    always_comb begin
        d = q;
        if (!run_i) begin
            d.cnt     = '0;
            d.expired = 1'b0;
        end else if (!q.expired) begin
            if (q.cnt == LIM_M1) begin
                d.expired = 1'b1;
            end else begin
                d.cnt = q.cnt + ONE;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired_o = q.expired;

endmodule // ufc_sync_timer

// file: dv/ufc_host_model.sv
// host model issuing word commands to the configuration register port
`timescale 1ns/100ps
module ufc_host_model (
    // clock
    input  wire logic        ref_clk_i,
    // word command port
    output logic             cmd_valid_o,
    output logic             cmd_write_o,
    output logic [7:0]       cmd_code_o,
    output logic [15:0]      cmd_wdata_o,
    input  wire logic        cmd_hit_i,
    input  wire logic        rd_valid_i,
    input  wire logic [15:0] rd_data_i
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o  = 8'h00;
        cmd_wdata_o = 16'h0000;
    end

    // one command; answer sampled while it stands, then lines scrambled
    task automatic xfer(input logic wr, input logic [7:0] code,
                        input logic [15:0] w, output logic [1:0] ans,
                        output logic [15:0] rd);
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b1;
        cmd_write_o = wr;
        cmd_code_o  = code;
        cmd_wdata_o = w & 16'hFF67;
        @(negedge ref_clk_i);
        ans = {cmd_hit_i, rd_valid_i};
        rd  = rd_data_i;
        cmd_valid_o = 1'b0;
        cmd_write_o = ~wr;
        cmd_code_o  = ~cmd_code_o;
        cmd_wdata_o = ~cmd_wdata_o;
    endtask
endmodule // ufc_host_model

// file: dv/ufc_top_test.sv
// self-checking bench of the user feature configuration register
`timescale 1ns/100ps
module ufc_top_test;
    localparam int unsigned TMO = 20;
    logic        ref_clk_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic        cmd_valid, cmd_write, cmd_hit, rd_valid;
    logic [7:0]  cmd_code, duty_req = 8'h00, duty;
    logic [15:0] cmd_wdata, rd_data, rdw;
    logic [1:0]  ans;
    logic        dev_en = 1'b1, ramp = 1'b1, seq_en = 1'b0;
    logic        ext_fault = 1'b0, tele_read = 1'b0, pp = 1'b1;
    logic        pwm_low = 1'b0, sw_clk = 1'b1, ext_sync = 1'b1;
    logic        ls_on, spin_o, oe_n, sync_rx, clk_ext, ff_corr, shut;
    logic        seq_down, lowpwr, mon_cont, mon_pulse, tele_av;
    int          mismatches = 0;
    int          checks = 0;
    // pin level: driven when enabled, else pulled up or held by peer
    wire         sync_wire = !oe_n ? spin_o : ext_sync;

    always #5 ref_clk_i = ~ref_clk_i;

    ufc_host_model i_ufc_host_model (.ref_clk_i(ref_clk_i),
        .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
        .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata),
        .cmd_hit_i(cmd_hit), .rd_valid_i(rd_valid), .rd_data_i(rd_data));

    ufc_top #(.SYNC_TMO_CYC(TMO)) i_ufc_top (.ref_clk_i(ref_clk_i),
        .srst_i(srst_i), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
        .cmd_code_i(cmd_code), .cmd_wdata_i(cmd_wdata),
        .cmd_hit_o(cmd_hit), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
        .dev_en_i(dev_en), .ramp_active_i(ramp), .seq_en_i(seq_en),
        .ext_fault_i(ext_fault), .tele_read_i(tele_read),
        .sync_drive_pp_i(pp), .duty_req_i(duty_req), .pwm_low_i(pwm_low),
        .sw_clk_i(sw_clk), .duty_o(duty), .ls_on_o(ls_on),
        .sync_pin_i(sync_wire), .sync_pin_o(spin_o),
        .sync_pin_oe_n_o(oe_n), .sync_rx_o(sync_rx), .clk_ext_o(clk_ext),
        .ff_correct_o(ff_corr), .shutdown_o(shut), .seq_down_o(seq_down),
        .lowpower_o(lowpwr), .mon_cont_o(mon_cont),
        .mon_pulse_o(mon_pulse), .tele_avail_o(tele_av));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic wr(input logic [15:0] w);
        i_ufc_host_model.xfer(1'b1, ufc_pkg::CMD_CODE, w, ans, rdw);
        chk(16'(ans), 16'h2);
        cyc(2);
    endtask
    task automatic rd(input logic [15:0] exp);
        i_ufc_host_model.xfer(1'b0, ufc_pkg::CMD_CODE, 16'h0000, ans, rdw);
        chk(16'(ans), 16'h3);
        chk(rdw, exp);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        cyc(20);
        srst_i = 1'b0;
        cyc(2);
        chk(16'(ff_corr), 16'h1);
        chk(16'(tele_av), 16'h1);
        rd(16'h2011);
        $display("test reset done");
        wr(16'hFFFF);
        rd(16'hEB67);
        i_ufc_host_model.xfer(1'b1, 8'hD0, 16'h0000, ans, rdw);
        chk(16'(ans), 16'h0);
        rd(16'hEB67);
        $display("test access done");
        for (int n = 0; n < 4; n++) begin
            wr({n[1:0], 14'h2000});
            chk(16'(duty), 16'(n + 1));
        end
        duty_req = 8'hC8;
        cyc(2);
        chk(16'(duty), 16'h00C8);
        duty_req = 8'h00;
        wr(16'hC000);
        chk(16'(duty), 16'h0);
        $display("test duty done");
        wr(16'h0240);
        chk(16'(ff_corr), 16'h0);
        chk(16'(clk_ext), 16'h1);
        ext_fault = 1'b1;
        wr(16'h0100);
        chk(16'(shut), 16'h1);
        wr(16'h0000);
        chk(16'({shut, seq_down}), 16'h0);
        seq_en = 1'b1;
        cyc(2);
        chk(16'({shut, seq_down}), 16'h1);
        ext_fault = 1'b0;
        seq_en = 1'b0;
        $display("test loop and fault done");
        wr(16'h0020);
        chk(16'({oe_n, spin_o}), 16'h1);
        pp = 1'b0;
        cyc(2);
        chk(16'(oe_n), 16'h1);
        sw_clk = 1'b0;
        cyc(4);
        chk(16'({oe_n, spin_o, sync_rx}), 16'h0);
        pp = 1'b1;
        wr(16'h0820);
        dev_en = 1'b0;
        cyc(10);
        chk(16'(oe_n), 16'h0);
        cyc(TMO);
        chk(16'(oe_n), 16'h1);
        cyc(3);
        chk(16'(sync_rx), 16'h1);
        dev_en = 1'b1;
        wr(16'h0020);
        dev_en = 1'b0;
        cyc(TMO + 10);
        chk(16'(oe_n), 16'h0);
        $display("test sync done");
        wr(16'h0004);
        chk(16'(ls_on), 16'h1);
        for (int m = 0; m < 4; m++) begin
            wr(16'(m));
            chk(16'(ls_on), 16'h0);
            chk(16'(lowpwr), 16'(m % 2 == 0));
            chk(16'(mon_cont), 16'(m == 1));
            chk(16'(tele_av), 16'(m % 2));
        end
        tele_read = 1'b1;
        cyc(1);
        tele_read = 1'b0;
        chk(16'(mon_pulse), 16'h1);
        dev_en = 1'b1;
        pwm_low = 1'b1;
        cyc(2);
        chk(16'({ls_on, tele_av}), 16'h3);
        $display("test standby done");
        wrap_up();
    end
endmodule // ufc_top_test
